// >>> verilog/status_consts.svh
// Constants for the status and memory integrity block
`ifndef STATUS_CONSTS_SVH
`define STATUS_CONSTS_SVH

// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define NVM_WORDS 53
`define NVM_AW 6
`define NVM_DW 16
`define NVM_CSUM_IDX 6'h34
`define NVM_CSUM_OFFSET 6'h35

// ----------------------------------------
// Register word offsets (index, byte address is four times)
// ----------------------------------------
`define REG_STATUS 8'h40
`define REG_IRQ_STAT 8'h41
`define REG_IRQ_MASK 8'h42
`define REG_NVM_SUM 8'h43
`define REG_NVM_BASE 8'h00

// ----------------------------------------
// Status byte bit positions
// ----------------------------------------
`define ST_POWERED 7
`define ST_BUSY 5
`define ST_MEM_ERR 2
`define ST_SAT 0
`define ST_SLEEP 6
`define ST_TEST 4
`define ST_CYCLIC 3
`define ST_CMD 1

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define IRQ_MEM_ERR 0
`define IRQ_SAT 1
`define IRQ_CHECK 2
`define IRQ_REJECT 3
`define IRQ_W 4

// ----------------------------------------
// Commands
// ----------------------------------------
`define CMD_STOP_CYCLIC 8'hbf
`define CMD_START_CYCLIC 8'hab
`define CMD_SLEEP 8'ha0
`define CMD_COMMAND_MODE 8'ha9
`define CMD_TEST_MODE 8'ha4
`define CMD_DONE_CYCLES 8'h04

`endif

// >>> verilog/status_pkg.sv
// Types for the status and memory integrity block
package status_pkg;
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_CMD,
    MODE_CYCLIC,
    MODE_TEST
  } mode_t;
endpackage

// >>> verilog/nvm_checker.sv
// Sequential checksum walk over the configuration memory
`timescale 1ns/1ps
`include "status_consts.svh"

module nvm_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic [`NVM_DW-1:0] rd_data,
  output logic [`NVM_AW-1:0] rd_addr,
  output logic [`NVM_DW-1:0] sum,
  output logic sum_valid
);
  logic [`NVM_AW-1:0] idx_q;
  logic [`NVM_DW-1:0] acc_q;

  assign rd_addr = idx_q;

  // ----------------------------------------
  // Walk words 0 .. last-1, summing
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst || restart) begin
      idx_q <= 6'h00;
      acc_q <= 16'h0000;
    end else if (idx_q == `NVM_CSUM_IDX) begin
      idx_q <= 6'h00;
      acc_q <= 16'h0000;
    end else begin
      idx_q <= idx_q + 6'h01;
      acc_q <= acc_q + rd_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sum <= 16'h0000;
      sum_valid <= 1'b0;
    end else if (!restart && idx_q == `NVM_CSUM_IDX) begin
      sum <= acc_q;
      sum_valid <= 1'b1;
    end else begin
      sum_valid <= 1'b0;
    end
  end
endmodule

// >>> verilog/status_block.sv
// Status reporting and configuration memory integrity
`timescale 1ns/1ps
`include "status_consts.svh"

// How it works
// - Busy refuses new commands except stop in cyclic mode; idle accepts them
// - Checksum mismatch raises memory error flag
// - Arithmetic range overflow raises saturation flag
// - Status shows sleep, test, cyclic, command
// - Sensor check flag follows self diagnostic
// - Memory holds 53 words, checksum last
// - New contents act only after reset
// - Reprogrammed data flags error until checksum
// - Memory writes only in command/sleep
// - Status byte leads every read sequence
// - Cyclic mode stays busy until stop
module status_block (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic cmd_accepted,
  output logic cmd_rejected,
  input wire logic rd_seq_start,
  output logic [7:0] status_byte,
  input wire logic alu_sat,
  input wire logic diag_fault,
  input wire logic powered,
  input wire logic [`NVM_AW-1:0] cfg_addr,
  output logic [`NVM_DW-1:0] cfg_data,
  output logic irq
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [`NVM_DW-1:0] nvm_q [0:`NVM_WORDS-1];
  logic [`NVM_DW-1:0] shadow_q [0:`NVM_WORDS-1];
  status_pkg::mode_t mode_q;
  logic busy_q;
  logic [7:0] busy_cnt_q;
  logic mem_err_q;
  logic sat_q;
  logic check_q;
  logic [1:0] pwr_sync_q;
  logic [1:0] sat_sync_q;
  logic [1:0] diag_sync_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [`IRQ_W-1:0] irq_ev;
  logic loaded_q;
  logic [`NVM_AW-1:0] load_idx_q;
  logic [`NVM_AW-1:0] chk_addr;
  logic [`NVM_DW-1:0] chk_sum;
  logic chk_valid;
  logic nvm_dirty;
  logic nvm_wr_ok;
  logic cmd_take;
  logic stop_take;
  logic [7:0] status_d;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pwr_sync_q <= 2'h0;
      sat_sync_q <= 2'h0;
      diag_sync_q <= 2'h0;
    end else begin
      pwr_sync_q <= {pwr_sync_q[0], powered};
      sat_sync_q <= {sat_sync_q[0], alu_sat};
      diag_sync_q <= {diag_sync_q[0], diag_fault};
    end
  end

  // ----------------------------------------
  // Command handling
  // ----------------------------------------
  assign cmd_take = cmd_valid && !busy_q;
  // Stop in cyclic mode bypasses busy
  assign stop_take = cmd_valid && cmd_code == `CMD_STOP_CYCLIC
                     && mode_q == status_pkg::MODE_CYCLIC;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cmd_accepted <= 1'b0;
      cmd_rejected <= 1'b0;
    end else begin
      cmd_accepted <= cmd_take || stop_take;
      cmd_rejected <= cmd_valid && busy_q && !stop_take;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= status_pkg::MODE_CMD;
    end else if (stop_take) begin
      mode_q <= status_pkg::MODE_CMD;
    end else if (cmd_take) begin
      unique case (cmd_code)
        `CMD_START_CYCLIC: mode_q <= status_pkg::MODE_CYCLIC;
        `CMD_SLEEP: mode_q <= status_pkg::MODE_SLEEP;
        `CMD_COMMAND_MODE: mode_q <= status_pkg::MODE_CMD;
        `CMD_TEST_MODE: mode_q <= status_pkg::MODE_TEST;
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Busy counts down after each accepted command except start cyclic and stop cyclic
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      busy_cnt_q <= 8'h00;
    end else if (mode_q == status_pkg::MODE_CYCLIC) begin
      busy_q <= !stop_take;
      busy_cnt_q <= 8'h00;
    end else if (cmd_take) begin
      busy_q <= 1'b1;
      busy_cnt_q <= `CMD_DONE_CYCLES;
    end else if (busy_cnt_q != 8'h00) begin
      busy_cnt_q <= busy_cnt_q - 8'h01;
      busy_q <= (busy_cnt_q != 8'h01);
    end else begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration memory
  // ----------------------------------------
  assign nvm_wr_ok = (mode_q == status_pkg::MODE_CMD)
                     || (mode_q == status_pkg::MODE_SLEEP);
  assign nvm_dirty = reg_wr && reg_addr < `NVM_WORDS && nvm_wr_ok;

  always_ff @(posedge ref_clk) begin
    if (nvm_dirty) begin
      nvm_q[reg_addr[`NVM_AW-1:0]] <= reg_wdata[`NVM_DW-1:0];
    end
  end

  // Shadow copy reloads word by word after reset only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      loaded_q <= 1'b0;
      load_idx_q <= 6'h00;
    end else if (!loaded_q) begin
      shadow_q[load_idx_q] <= nvm_q[load_idx_q];
      load_idx_q <= load_idx_q + 6'h01;
      loaded_q <= (load_idx_q == `NVM_CSUM_IDX);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_data <= 16'h0000;
    end else if (cfg_addr < `NVM_WORDS) begin
      cfg_data <= shadow_q[cfg_addr];
    end else begin
      cfg_data <= 16'h0000;
    end
  end

  nvm_checker u_chk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .restart(nvm_dirty),
    .rd_data(nvm_q[chk_addr]),
    .rd_addr(chk_addr),
    .sum(chk_sum),
    .sum_valid(chk_valid)
  );

  // Compare on each fresh walk result
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mem_err_q <= 1'b0;
    end else if (chk_valid) begin
      mem_err_q <= (chk_sum != nvm_q[`NVM_CSUM_IDX]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sat_q <= 1'b0;
      check_q <= 1'b0;
    end else begin
      sat_q <= sat_sync_q[1];
      check_q <= diag_sync_q[1];
    end
  end

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  always_comb begin
    status_d = 8'h00;
    status_d[`ST_POWERED] = pwr_sync_q[1];
    status_d[`ST_BUSY] = busy_q;
    status_d[`ST_MEM_ERR] = mem_err_q;
    status_d[`ST_SAT] = sat_q | check_q;
    status_d[`ST_SLEEP] = (mode_q == status_pkg::MODE_SLEEP);
    status_d[`ST_TEST] = (mode_q == status_pkg::MODE_TEST);
    status_d[`ST_CYCLIC] = (mode_q == status_pkg::MODE_CYCLIC);
    status_d[`ST_CMD] = (mode_q == status_pkg::MODE_CMD);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      status_byte <= 8'h00;
    end else if (rd_seq_start) begin
      status_byte <= status_d;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_ev = {cmd_valid && busy_q && !stop_take, check_q, sat_q, mem_err_q};

  // Write one clears; a fresh event wins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_stat_q <= 4'h0;
    end else if (reg_wr && reg_addr == `REG_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[`IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_mask_q <= 4'h0;
    end else if (reg_wr && reg_addr == `REG_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr < `NVM_WORDS) begin
        reg_rdata <= {16'h0000, nvm_q[reg_addr[`NVM_AW-1:0]]};
      end else if (reg_addr == `REG_STATUS) begin
        reg_rdata <= {24'h000000, status_d};
      end else if (reg_addr == `REG_IRQ_STAT) begin
        reg_rdata <= {28'h0000000, irq_stat_q};
      end else if (reg_addr == `REG_IRQ_MASK) begin
        reg_rdata <= {28'h0000000, irq_mask_q};
      end else if (reg_addr == `REG_NVM_SUM) begin
        reg_rdata <= {16'h0000, chk_sum};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  busy_refuse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd_valid && busy_q && !stop_take |=> cmd_rejected && !cmd_accepted)
    else $error("busy did not refuse command");
  idle_accept_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd_valid && !busy_q |=> cmd_accepted)
    else $error("idle did not accept command");
  mem_err_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    chk_valid && chk_sum != nvm_q[`NVM_CSUM_IDX] && !nvm_dirty |=> mem_err_q)
    else $error("checksum mismatch not flagged");
  sat_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(sat_sync_q[1]) |=> sat_q)
    else $error("saturation not flagged");
  one_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $onehot({status_d[`ST_SLEEP], status_d[`ST_TEST], status_d[`ST_CYCLIC], status_d[`ST_CMD]}))
    else $error("mode bits not one hot");
  sensor_check_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    diag_sync_q[1] |=> check_q)
    else $error("sensor check not flagged");
  cyclic_busy_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_q == status_pkg::MODE_CYCLIC && !(cmd_valid && cmd_code == `CMD_STOP_CYCLIC)
    |=> busy_q)
    else $error("cyclic mode not busy");
  nvm_guard_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    nvm_dirty |-> mode_q == status_pkg::MODE_CMD || mode_q == status_pkg::MODE_SLEEP)
    else $error("memory write outside allowed mode");
  status_seq_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_seq_start |=> status_byte[`ST_BUSY] == $past(busy_q))
    else $error("status byte not captured");
  stop_accept_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stop_take |=> cmd_accepted && !cmd_rejected && !busy_q
      && mode_q == status_pkg::MODE_CMD)
    else $error("stop command not taken");
  mode_stay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd_valid && busy_q && !stop_take |=> mode_q == $past(mode_q))
    else $error("refused command changed mode");
  busy_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cmd_take |=> busy_q)
    else $error("accepted command not busy");
  busy_end_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    busy_cnt_q == 8'h01 && mode_q != status_pkg::MODE_CYCLIC && !cmd_take
    |=> !busy_q)
    else $error("busy did not end");
  mem_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    chk_valid && chk_sum == nvm_q[`NVM_CSUM_IDX] |=> !mem_err_q)
    else $error("matching checksum left error set");
  status_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !rd_seq_start |=> $stable(status_byte))
    else $error("status byte changed between reads");
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside read cycle");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    |(irq_stat_q & irq_mask_q) |=> irq)
    else $error("interrupt level missing");
  irq_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq_ev[`IRQ_SAT] |=> irq_stat_q[`IRQ_SAT])
    else $error("event lost against clear");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  cyc_cover_c: cover property (@(posedge ref_clk) mode_q == status_pkg::MODE_CYCLIC);
  rej_cover_c: cover property (@(posedge ref_clk) cmd_rejected);
  err_cover_c: cover property (@(posedge ref_clk) mem_err_q);
  stop_cover_c: cover property (@(posedge ref_clk) stop_take);
  clear_cover_c: cover property (@(posedge ref_clk) $fell(mem_err_q));
endmodule

// >>> bench/host_model.sv
// Host controller model issuing commands and read sequences
`timescale 1ns/1ps

module host_model (
  input wire logic ref_clk,
  input wire logic cmd_accepted,
  input wire logic cmd_rejected,
  input wire logic [7:0] status_byte,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic rd_seq_start
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    rd_seq_start = 1'b0;
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // Memory writes only come from the bench scenarios
  task automatic send_cmd(input logic [7:0] code, output logic acc, output logic rej);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    #1;
    acc = cmd_accepted;
    rej = cmd_rejected;
  endtask

  task automatic read_status(output logic [7:0] sb);
    @(posedge ref_clk);
    rd_seq_start <= 1'b1;
    @(posedge ref_clk);
    rd_seq_start <= 1'b0;
    #1;
    sb = status_byte;
  endtask
endmodule

// >>> bench/tb.sv
// Testbench for the status and memory integrity block
`timescale 1ns/1ps
`include "status_consts.svh"

module tb;
  logic ref_clk, nrst, reg_wr, reg_rd, alu_sat, diag_fault, powered, irq, acc, rej;
  logic [7:0] reg_addr, status_byte, cmd_code, sb;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic cmd_valid, cmd_accepted, cmd_rejected, rd_seq_start;
  logic [`NVM_AW-1:0] cfg_addr;
  logic [`NVM_DW-1:0] cfg_data;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] codes [3] = '{`CMD_SLEEP, `CMD_TEST_MODE, `CMD_COMMAND_MODE};
  int bits [3] = '{`ST_SLEEP, `ST_TEST, `ST_CMD};

  status_block i_status_block (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_accepted(cmd_accepted),
    .cmd_rejected(cmd_rejected), .rd_seq_start(rd_seq_start), .status_byte(status_byte),
    .alu_sat(alu_sat), .diag_fault(diag_fault), .powered(powered), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .irq(irq));
  host_model i_host_model (.ref_clk(ref_clk), .cmd_accepted(cmd_accepted),
    .cmd_rejected(cmd_rejected), .status_byte(status_byte), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rd_seq_start(rd_seq_start));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stat_bit(input int b, input logic e);
    rd(`REG_STATUS, rv);
    chk("status bit", {31'h0, e}, {31'h0, rv[b]});
  endtask

  task automatic cmd(input logic [7:0] c);
    i_host_model.send_cmd(c, acc, rej);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (120) @(posedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {nrst, reg_wr, reg_rd, alu_sat, diag_fault} = 5'h00;
    powered = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    cfg_addr = 6'h05;
    do_reset();
    for (int i = 0; i < 52; i++) wr(i[7:0], i);
    wr({2'b00, `NVM_CSUM_IDX}, 32'h0);
    do_reset();
    chk("cfg word", 32'h5, {16'h0, cfg_data});
    i_host_model.read_status(sb);
    chk("status byte", 32'h86, {24'h0, sb});
    stat_bit(`ST_MEM_ERR, 1'b1);
    rd(`REG_IRQ_STAT, rv);
    chk("irq mem err", 32'h1, {31'h0, rv[`IRQ_MEM_ERR]});
    rd(8'h03, rv);
    chk("mem word", 32'h3, rv);
    wr(8'h05, 32'haa);
    chk("cfg word", 32'h5, {16'h0, cfg_data});
    wr({2'b00, `NVM_CSUM_IDX}, 32'h5d3);
    repeat (120) @(posedge ref_clk);
    stat_bit(`ST_MEM_ERR, 1'b0);
    do_reset();
    chk("cfg word", 32'haa, {16'h0, cfg_data});
    stat_bit(`ST_MEM_ERR, 1'b0);
    rd(`REG_NVM_SUM, rv);
    chk("nvm sum", 32'h5d3, rv);
    wr(`REG_IRQ_MASK, 32'h0);
    wr(`REG_IRQ_STAT, 32'hf);
    @(posedge ref_clk) alu_sat <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    stat_bit(`ST_SAT, 1'b1);
    rd(`REG_IRQ_STAT, rv);
    chk("irq sat", 32'h1, {31'h0, rv[`IRQ_SAT]});
    wr(`REG_IRQ_MASK, 32'h2);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge ref_clk) alu_sat <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(`REG_IRQ_STAT, 32'h2);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge ref_clk) diag_fault <= 1'b1;
    repeat (6) @(posedge ref_clk);
    stat_bit(`ST_SAT, 1'b1);
    rd(`REG_IRQ_STAT, rv);
    chk("irq check", 32'h1, {31'h0, rv[`IRQ_CHECK]});
    @(posedge ref_clk) diag_fault <= 1'b0;
    repeat (6) @(posedge ref_clk);
    stat_bit(`ST_SAT, 1'b0);
    for (int k = 0; k < 3; k++) begin
      cmd(codes[k]);
      chk("accepted", 32'h1, {31'h0, acc});
      repeat (6) @(posedge ref_clk);
      stat_bit(bits[k], 1'b1);
    end
    cmd(`CMD_COMMAND_MODE);
    cmd(`CMD_COMMAND_MODE);
    chk("rejected", 32'h1, {31'h0, rej});
    rd(`REG_IRQ_STAT, rv);
    chk("irq reject", 32'h1, {31'h0, rv[`IRQ_REJECT]});
    repeat (6) @(posedge ref_clk);
    cmd(`CMD_START_CYCLIC);
    repeat (6) @(posedge ref_clk);
    stat_bit(`ST_BUSY, 1'b1);
    stat_bit(`ST_CYCLIC, 1'b1);
    wr(8'h03, 32'hffff);
    rd(8'h03, rv);
    chk("mem word", 32'h3, rv);
    cmd(`CMD_COMMAND_MODE);
    chk("rejected", 32'h1, {31'h0, rej});
    cmd(`CMD_STOP_CYCLIC);
    chk("accepted", 32'h1, {31'h0, acc});
    stat_bit(`ST_BUSY, 1'b0);
    stat_bit(`ST_CMD, 1'b1);
    rd(8'h50, rv);
    chk("unmapped", 32'h0, rv);
    report_and_stop();
  end
endmodule
